// [include/ffa_params.svh]
// Register map, field positions, reset values for the fault flag aggregator
`ifndef FFA_PARAMS_SVH
`define FFA_PARAMS_SVH
`define FFA_ADDR_W 12
`define FFA_OFS_SUMMARY 12'h2c0
`define FFA_OFS_STATUS 12'h2c1
`define FFA_OFS_MASK 12'h2c2
`define FFA_OFS_LANE 12'h2c4
`define FFA_BIT_LANE 5
`define FFA_BIT_PLL 4
`define FFA_BIT_LINK 3
`define FFA_BIT_REALIGN 2
`define FFA_BIT_RSVD1 1
`define FFA_BIT_CLK 0
`define FFA_STATUS_RESET 8'h3f
`define FFA_MASK_RESET 8'h3f
`define FFA_LANE_RESET 8'hff
`define FFA_FAULT_BITS 8'h3f
`endif

// [include/ffa_pkg.sv]
// Types shared by the fault flag aggregator
package ffa_pkg;
  typedef enum logic {FFA_ENC_8B10B, FFA_ENC_64B66B} ffa_enc_e;
  // Register access request from the configuration port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } ffa_req_s;
  // Raw fault conditions from the link and clocking
  typedef struct packed {
    logic [7:0] lane_err;
    logic pll_unlock;
    logic link_enable;
    logic data_xmit_state;
    logic realign_event;
    logic sysref_realign;
    logic div_mismatch;
  } ffa_src_s;
endpackage : ffa_pkg

// [src/ffa_sync.sv]
// Two-flop synchroniser bank for asynchronous fault sources
module ffa_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : ffa_sync

// [src/ffa_top.sv]
// Fault flag aggregator: sticky fault status, mask, summary and pin routing
`include "ffa_params.svh"
module ffa_top import ffa_pkg::*; #(
  parameter int LANES = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  // Configuration port
  input wire ffa_req_s req,
  output logic [7:0] rdata_q,
  // Mode and pin select
  input wire ffa_enc_e enc_mode,
  input wire logic calib_sel,
  input wire logic calib_other,
  // Fault sources (asynchronous)
  input wire ffa_src_s src,
  // Outputs
  output logic calib_status_pin,
  output logic summary_q
);
  localparam int SRCW = LANES + 6;

  logic [SRCW-1:0] sync_d;
  ffa_src_s s;
  logic [7:0] fault_status_bits_q;
  logic [7:0] fault_mask_bits_q;
  logic [7:0] per_lane_buffer_fault_q;
  logic [7:0] set_v;
  logic link_en_q;
  logic startup_pulse;
  logic wr_status;
  logic wr_mask;
  logic wr_lane;
  logic sum_d;
  logic init_n;

  // Asynchronous sources pass two flops first
  ffa_sync #(.WIDTH(SRCW)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .din(src),
    .dout(sync_d)
  );
  assign s = ffa_src_s'(sync_d);
  assign init_n = rst_n && !soft_reset;

  assign wr_status = req.wr && (req.addr == `FFA_OFS_STATUS);
  assign wr_mask = req.wr && (req.addr == `FFA_OFS_MASK);
  assign wr_lane = req.wr && (req.addr == `FFA_OFS_LANE);

  // Link enable history for the startup edge in 64b/66b
  always_ff @(posedge ref_clk) begin
    if (!init_n) begin
      link_en_q <= 1'b0;
    end else begin
      link_en_q <= s.link_enable;
    end
  end
  assign startup_pulse = s.link_enable && !link_en_q;

  // Set conditions per status bit
  always_comb begin
    set_v = 8'h00;
    set_v[`FFA_BIT_LANE] = |s.lane_err;
    set_v[`FFA_BIT_PLL] = s.pll_unlock;
    if (enc_mode == FFA_ENC_8B10B) begin
      set_v[`FFA_BIT_LINK] = s.link_enable && !s.data_xmit_state;
    end else begin
      set_v[`FFA_BIT_LINK] = startup_pulse || s.realign_event;
    end
    set_v[`FFA_BIT_REALIGN] = s.sysref_realign;
    set_v[`FFA_BIT_CLK] = s.div_mismatch;
  end

  // Sticky status; set beats a write-one clear, and bits reset set, so they are
  // meaningful only once software clears them after enabling the link
  always_ff @(posedge ref_clk) begin
    if (!init_n) begin
      fault_status_bits_q <= `FFA_STATUS_RESET;
    end else begin
      fault_status_bits_q <= ((fault_status_bits_q
        & ~(wr_status ? req.wdata : 8'h00)) | set_v)
        & `FFA_FAULT_BITS;
    end
  end

  // Mask register, reserved high bits held zero
  always_ff @(posedge ref_clk) begin
    if (!init_n) begin
      fault_mask_bits_q <= `FFA_MASK_RESET;
    end else if (wr_mask) begin
      fault_mask_bits_q <= req.wdata & `FFA_FAULT_BITS;
    end
  end

  // Per-lane buffer faults; clearing combined bit clears all lanes
  always_ff @(posedge ref_clk) begin
    if (!init_n) begin
      per_lane_buffer_fault_q <= `FFA_LANE_RESET;
    end else begin
      per_lane_buffer_fault_q <= (per_lane_buffer_fault_q
        & ~(wr_lane ? req.wdata : 8'h00)
        & ~((wr_status && req.wdata[`FFA_BIT_LANE]) ? 8'hff : 8'h00))
        | s.lane_err;
    end
  end

  // Summary over the reserved bit 1 too, masked by its own mask bit
  assign sum_d = |(fault_status_bits_q & ~fault_mask_bits_q);

  // Summary and pin driven from flops
  always_ff @(posedge ref_clk) begin
    if (!init_n) begin
      summary_q <= 1'b0;
      calib_status_pin <= 1'b0;
    end else begin
      summary_q <= sum_d;
      calib_status_pin <= calib_sel ? sum_d : calib_other;
    end
  end

  // Registered read data; unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (req.rd) begin
      case (req.addr)
        `FFA_OFS_SUMMARY: rdata_q <= {7'h00, sum_d};
        `FFA_OFS_STATUS: rdata_q <= fault_status_bits_q;
        `FFA_OFS_MASK: rdata_q <= fault_mask_bits_q;
        `FFA_OFS_LANE: rdata_q <= per_lane_buffer_fault_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // Summary follows unmasked status one cycle later
  a_summary_tracks: assert property (@(posedge ref_clk) disable iff (!init_n)
    $past(init_n) |-> summary_q == |($past(fault_status_bits_q) & ~$past(fault_mask_bits_q)))
    else $error("summary mismatch");
  a_pll_sticky: assert property (@(posedge ref_clk) disable iff (!init_n)
    s.pll_unlock |=> fault_status_bits_q[`FFA_BIT_PLL])
    else $error("pll fault not set");
  a_w1c_clear: assert property (@(posedge ref_clk) disable iff (!init_n)
    (wr_status && req.wdata[`FFA_BIT_CLK] && !s.div_mismatch)
    |=> !fault_status_bits_q[`FFA_BIT_CLK])
    else $error("clear failed");
  a_hold_set: assert property (@(posedge ref_clk) disable iff (!init_n)
    (fault_status_bits_q[`FFA_BIT_LINK] && !wr_status)
    |=> fault_status_bits_q[`FFA_BIT_LINK])
    else $error("status bit lost");
  a_set_wins: assert property (@(posedge ref_clk) disable iff (!init_n)
    (wr_status && s.sysref_realign) |=> fault_status_bits_q[`FFA_BIT_REALIGN])
    else $error("set lost to clear");
  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!init_n)
    fault_status_bits_q[7:6] == 2'b00 && fault_mask_bits_q[7:6] == 2'b00)
    else $error("reserved bits set");
  a_reset_val: assert property (@(posedge ref_clk)
    !init_n |=> fault_status_bits_q == `FFA_STATUS_RESET)
    else $error("bad reset value");
  a_lane_all: assert property (@(posedge ref_clk) disable iff (!init_n)
    (wr_status && req.wdata[`FFA_BIT_LANE] && s.lane_err == 8'h00)
    |=> per_lane_buffer_fault_q == 8'h00)
    else $error("lane bits not cleared");
  a_pin_route: assert property (@(posedge ref_clk) disable iff (!init_n)
    $past(calib_sel) |-> calib_status_pin == summary_q)
    else $error("pin not routed");
  a_link_8b: assert property (@(posedge ref_clk) disable iff (!init_n)
    (enc_mode == FFA_ENC_8B10B && s.link_enable && !s.data_xmit_state)
    |=> fault_status_bits_q[`FFA_BIT_LINK])
    else $error("link fault missed");

  // Each synced source lands in its status bit one edge later
  a_lane_sets: assert property (@(posedge ref_clk) disable iff (!init_n)
    (|s.lane_err) |=> fault_status_bits_q[`FFA_BIT_LANE])
    else $error("lane fault not set");
  a_realign_sets: assert property (@(posedge ref_clk) disable iff (!init_n)
    s.sysref_realign |=> fault_status_bits_q[`FFA_BIT_REALIGN])
    else $error("realign fault not set");
  a_clk_sets: assert property (@(posedge ref_clk) disable iff (!init_n)
    s.div_mismatch |=> fault_status_bits_q[`FFA_BIT_CLK])
    else $error("clock fault not set");

  // 64b/66b: start-up edge and realignment flag the link
  a_link_start: assert property (@(posedge ref_clk) disable iff (!init_n)
    (enc_mode == FFA_ENC_64B66B && $rose(s.link_enable))
    |=> fault_status_bits_q[`FFA_BIT_LINK])
    else $error("start-up not flagged");
  a_link_realign: assert property (@(posedge ref_clk) disable iff (!init_n)
    (enc_mode == FFA_ENC_64B66B && s.realign_event)
    |=> fault_status_bits_q[`FFA_BIT_LINK])
    else $error("realignment not flagged");

  // A steady 64b/66b link must not flag; the cycle after reset is skipped
  // because the enable history restarts there
  a_link_steady: assert property (@(posedge ref_clk) disable iff (!init_n)
    (enc_mode == FFA_ENC_64B66B && $past(init_n) && !s.realign_event
    && !$rose(s.link_enable) && !fault_status_bits_q[`FFA_BIT_LINK])
    |=> !fault_status_bits_q[`FFA_BIT_LINK])
    else $error("spurious 64b/66b link fault");

  // 8b/10b: a transmitting or disabled link leaves the bit alone
  a_link_8b_quiet: assert property (@(posedge ref_clk) disable iff (!init_n)
    (enc_mode == FFA_ENC_8B10B && !(s.link_enable && !s.data_xmit_state)
    && !fault_status_bits_q[`FFA_BIT_LINK]) |=> !fault_status_bits_q[`FFA_BIT_LINK])
    else $error("spurious 8b/10b link fault");

  // Nothing in hardware raises reserved bit 1; only reset does
  a_rsvd1_quiet: assert property (@(posedge ref_clk) disable iff (!init_n)
    !fault_status_bits_q[`FFA_BIT_RSVD1] |=> !fault_status_bits_q[`FFA_BIT_RSVD1])
    else $error("reserved status bit raised");

  // Write-one clears a quiet source; write-zero leaves the bit set
  a_w1c_pll: assert property (@(posedge ref_clk) disable iff (!init_n)
    (wr_status && req.wdata[`FFA_BIT_PLL] && !s.pll_unlock)
    |=> !fault_status_bits_q[`FFA_BIT_PLL])
    else $error("pll clear failed");
  a_w1c_lane: assert property (@(posedge ref_clk) disable iff (!init_n)
    (wr_status && req.wdata[`FFA_BIT_LANE] && s.lane_err == 8'h00)
    |=> !fault_status_bits_q[`FFA_BIT_LANE])
    else $error("lane clear failed");
  a_keep_pll: assert property (@(posedge ref_clk) disable iff (!init_n)
    (fault_status_bits_q[`FFA_BIT_PLL] && !(wr_status && req.wdata[`FFA_BIT_PLL]))
    |=> fault_status_bits_q[`FFA_BIT_PLL])
    else $error("pll bit lost");
  a_keep_clk: assert property (@(posedge ref_clk) disable iff (!init_n)
    (fault_status_bits_q[`FFA_BIT_CLK] && !(wr_status && req.wdata[`FFA_BIT_CLK]))
    |=> fault_status_bits_q[`FFA_BIT_CLK])
    else $error("clock bit lost");
  a_keep_realign: assert property (@(posedge ref_clk) disable iff (!init_n)
    (fault_status_bits_q[`FFA_BIT_REALIGN] && !(wr_status && req.wdata[`FFA_BIT_REALIGN]))
    |=> fault_status_bits_q[`FFA_BIT_REALIGN])
    else $error("realign bit lost");

  // A persisting fault beats a clear in the same cycle
  a_set_wins_lane: assert property (@(posedge ref_clk) disable iff (!init_n)
    (wr_status && |s.lane_err) |=> fault_status_bits_q[`FFA_BIT_LANE])
    else $error("lane set lost to clear");
  a_set_wins_clk: assert property (@(posedge ref_clk) disable iff (!init_n)
    (wr_status && s.div_mismatch) |=> fault_status_bits_q[`FFA_BIT_CLK])
    else $error("clock set lost to clear");

  // Mask changes only by a write, with reserved bits forced low
  a_mask_write: assert property (@(posedge ref_clk) disable iff (!init_n)
    wr_mask |=> fault_mask_bits_q == ($past(req.wdata) & `FFA_FAULT_BITS))
    else $error("mask write lost");
  a_mask_hold: assert property (@(posedge ref_clk) disable iff (!init_n)
    !wr_mask |=> $stable(fault_mask_bits_q))
    else $error("mask changed unasked");
  a_mask_reset: assert property (@(posedge ref_clk)
    !init_n |=> fault_mask_bits_q == `FFA_MASK_RESET)
    else $error("bad mask reset value");

  // Lane bits: reset to all ones, sticky, cleared per lane or all at once
  a_lane_reset: assert property (@(posedge ref_clk)
    !init_n |=> per_lane_buffer_fault_q == `FFA_LANE_RESET)
    else $error("bad lane reset value");
  a_lane_w1c: assert property (@(posedge ref_clk) disable iff (!init_n)
    (wr_lane && s.lane_err == 8'h00)
    |=> (per_lane_buffer_fault_q & $past(req.wdata)) == 8'h00)
    else $error("lane bit not cleared");
  a_lane_sticky: assert property (@(posedge ref_clk) disable iff (!init_n)
    (!wr_lane && !(wr_status && req.wdata[`FFA_BIT_LANE]))
    |=> ($past(per_lane_buffer_fault_q) & ~per_lane_buffer_fault_q) == 8'h00)
    else $error("lane bit lost");
  a_lane_latch: assert property (@(posedge ref_clk) disable iff (!init_n)
    (|s.lane_err)
    |=> (per_lane_buffer_fault_q & $past(s.lane_err)) == $past(s.lane_err))
    else $error("lane bit not set");

  // Summary flop agrees with the unmasked status of the cycle before
  a_sum_high: assert property (@(posedge ref_clk) disable iff (!init_n)
    ((fault_status_bits_q & ~fault_mask_bits_q) != 8'h00) |=> summary_q)
    else $error("summary stuck low");
  a_sum_low: assert property (@(posedge ref_clk) disable iff (!init_n)
    ((fault_status_bits_q & ~fault_mask_bits_q) == 8'h00) |=> !summary_q)
    else $error("summary stuck high");

  // Pin shows the other status one edge after the select drops
  a_pin_other: assert property (@(posedge ref_clk) disable iff (!init_n)
    !calib_sel |=> calib_status_pin == $past(calib_other))
    else $error("pin not released");

  // Read port returns status, mask and lane as they stood at the read edge; summary as the summary flop loads it there
  a_rd_summary: assert property (@(posedge ref_clk) disable iff (!init_n)
    (req.rd && req.addr == `FFA_OFS_SUMMARY) |=> rdata_q == {7'h00, summary_q})
    else $error("summary read wrong");
  a_rd_status: assert property (@(posedge ref_clk) disable iff (!init_n)
    (req.rd && req.addr == `FFA_OFS_STATUS) |=> rdata_q == $past(fault_status_bits_q))
    else $error("status read wrong");
  a_rd_mask: assert property (@(posedge ref_clk) disable iff (!init_n)
    (req.rd && req.addr == `FFA_OFS_MASK) |=> rdata_q == $past(fault_mask_bits_q))
    else $error("mask read wrong");
  a_rd_lane: assert property (@(posedge ref_clk) disable iff (!init_n)
    (req.rd && req.addr == `FFA_OFS_LANE) |=> rdata_q == $past(per_lane_buffer_fault_q))
    else $error("lane read wrong");
  // Unmapped reads give zero, and read data stands until the next read
  a_rd_unmapped: assert property (@(posedge ref_clk) disable iff (!init_n)
    (req.rd && req.addr != `FFA_OFS_SUMMARY && req.addr != `FFA_OFS_STATUS
    && req.addr != `FFA_OFS_MASK && req.addr != `FFA_OFS_LANE) |=> rdata_q == 8'h00)
    else $error("unmapped read not zero");
  a_rd_hold: assert property (@(posedge ref_clk) disable iff (!init_n)
    !req.rd |=> $stable(rdata_q))
    else $error("read data moved");
endmodule : ffa_top

// [test/tb_top.sv]
// Self-checking bench for the fault flag aggregator
`include "ffa_params.svh"
module tb_top import ffa_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic calib_sel = 1'b1;
  logic calib_other = 1'b0;
  ffa_req_s req = '0;
  ffa_src_s src = ffa_src_s'(14'h0018);
  ffa_enc_e enc_mode = FFA_ENC_8B10B;
  logic [7:0] rdata_q;
  logic calib_status_pin;
  logic summary_q;
  int failures = 0;
  int tests_run = 0;
  // Quiet sources: link enabled and transmitting
  localparam logic [13:0] QUIET = 14'h0018;
  logic [13:0] sv [5] = '{14'h0118, 14'h0038, 14'h0010, 14'h001a, 14'h0019};
  logic [7:0] se [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h01};

  // 25 ns clock
  always #12.5 ref_clk = ~ref_clk;

  ffa_top i_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .soft_reset(soft_reset), .req(req),
    .rdata_q(rdata_q), .enc_mode(enc_mode), .calib_sel(calib_sel),
    .calib_other(calib_other), .src(src), .calib_status_pin(calib_status_pin),
    .summary_q(summary_q)
  );

  task final_report;
    if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Inputs always move 2 ns after the edge
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : cyc

  task wr(input logic [11:0] a, input logic [7:0] d);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    cyc(1);
    req.wr = 1'b0;
  endtask : wr

  // Read data is registered, so look one edge after the strobe is taken
  task rd(input logic [11:0] a, input logic [7:0] e);
    req.addr = a;
    req.rd = 1'b1;
    cyc(1);
    req.rd = 1'b0;
    cyc(1);
    chk(rdata_q, e);
  endtask : rd

  // Sources cross two sync flops plus the status register
  task set_src(input logic [13:0] v);
    src = ffa_src_s'(v);
    cyc(5);
  endtask : set_src

  task t_reset;
    rd(`FFA_OFS_STATUS, 8'h3f);
    rd(`FFA_OFS_MASK, 8'h3f);
    rd(`FFA_OFS_LANE, 8'hff);
    rd(`FFA_OFS_SUMMARY, 8'h00);
  endtask : t_reset

  task t_clear;
    wr(`FFA_OFS_STATUS, 8'h00);
    rd(`FFA_OFS_STATUS, 8'h3f);
    wr(`FFA_OFS_STATUS, 8'hff);
    rd(`FFA_OFS_STATUS, 8'h00);
    wr(`FFA_OFS_LANE, 8'hff);
    rd(`FFA_OFS_LANE, 8'h00);
    wr(`FFA_OFS_SUMMARY, 8'hff);
    rd(12'h2c3, 8'h00);
  endtask : t_clear

  // Pulse each source, then check stickiness and clearing
  task t_sources;
    for (int i = 0; i < 5; i++) begin
      set_src(sv[i]);
      set_src(QUIET);
      rd(`FFA_OFS_STATUS, se[i]);
      rd(`FFA_OFS_LANE, (i == 0) ? 8'h04 : 8'h00);
      wr(`FFA_OFS_STATUS, se[i]);
      rd(`FFA_OFS_STATUS, 8'h00);
      rd(`FFA_OFS_LANE, 8'h00);
    end
  endtask : t_sources

  // Reserved mask bits are written high on purpose and must read back low
  task t_summary;
    set_src(14'h0038);
    wr(`FFA_OFS_MASK, 8'hef);
    cyc(3);
    chk({7'h0, summary_q}, 8'h01);
    chk({7'h0, calib_status_pin}, 8'h01);
    rd(`FFA_OFS_SUMMARY, 8'h01);
    rd(`FFA_OFS_MASK, 8'h2f);
    calib_sel = 1'b0;
    cyc(3);
    chk({7'h0, calib_status_pin}, 8'h00);
    calib_sel = 1'b1;
    wr(`FFA_OFS_MASK, 8'h3f);
    cyc(3);
    chk({7'h0, summary_q}, 8'h00);
    calib_sel = 1'b0;
    calib_other = 1'b1;
    cyc(3);
    chk({7'h0, calib_status_pin}, 8'h01);
    calib_sel = 1'b1;
    calib_other = 1'b0;
    cyc(3);
    chk({7'h0, calib_status_pin}, 8'h00);
    wr(`FFA_OFS_STATUS, 8'h10);
    rd(`FFA_OFS_STATUS, 8'h10);
    set_src(QUIET);
    wr(`FFA_OFS_STATUS, 8'h10);
    rd(`FFA_OFS_STATUS, 8'h00);
  endtask : t_summary

  // Link off, clear, then start-up and realignment both flag the link
  task t_66b;
    enc_mode = FFA_ENC_64B66B;
    set_src(14'h0008);
    wr(`FFA_OFS_STATUS, 8'hff);
    set_src(QUIET);
    rd(`FFA_OFS_STATUS, 8'h08);
    wr(`FFA_OFS_STATUS, 8'h08);
    set_src(14'h001c);
    set_src(QUIET);
    rd(`FFA_OFS_STATUS, 8'h08);
    wr(`FFA_OFS_STATUS, 8'h08);
    enc_mode = FFA_ENC_8B10B;
  endtask : t_66b

  // Mask is cleared first so that the soft reset has something to undo
  task t_soft;
    wr(`FFA_OFS_MASK, 8'h00);
    soft_reset = 1'b1;
    cyc(1);
    soft_reset = 1'b0;
    rd(`FFA_OFS_STATUS, 8'h3f);
    rd(`FFA_OFS_MASK, 8'h3f);
    rd(`FFA_OFS_LANE, 8'hff);
    rd(`FFA_OFS_SUMMARY, 8'h00);
  endtask : t_soft

  // Main sequence after 20 cycles of reset
  initial begin
    cyc(20);
    rst_n = 1'b1;
    t_reset();
    t_clear();
    t_sources();
    t_summary();
    t_66b();
    t_soft();
    final_report();
  end

  // Whole run is about two hundred cycles; this is far beyond it
  initial begin
    #50us;
    failures++;
    final_report();
  end
endmodule : tb_top
